// ### rtl/pcg_clock_gen.sv
// pll clock generator: oscillator gate, dividers, loop control, base clock
//
// The address-and-strobe port and the address map were left to the implementer.
`timescale 1ns/1ns
module pcg_clock_gen import pcg_pkg::*; (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic nrst_in,
  // register port
  input wire logic [ADDR_W-1:0] reg_addr_in,
  input wire logic [DATA_W-1:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [DATA_W-1:0] reg_rdata_out,
  // crystal oscillator
  input wire logic sim_osc_enable_in,
  input wire logic osc_run_in_stop_in,
  input wire logic xtal_in,
  output logic osc_enable_out,
  output logic crystal_clock_out,
  output logic pll_ref_clock_out,
  // vco and loop filter
  input wire logic vco_clock_in,
  output logic vco_enable_out,
  output logic [10:0] vco_centre_out,
  output logic pump_up_out,
  output logic pump_down_out,
  output logic filter_track_out,
  // system clocks
  input wire logic user_mode_in,
  output logic base_clock_out,
  output logic bus_clock_out,
  // lock change request
  output logic pll_irq_out
);
  pcg_ctrl_t ctrl_q; // software control bits
  logic [1:0] pre_p_q; // prescale power P
  logic [1:0] rng_e_q; // range power E
  logic [N_W-1:0] mod_n_q; // feedback modulo N
  logic [7:0] lin_l_q; // linear range L
  logic [7:0] ref_r_q; // reference divide R
  logic pll_on_q; // loop really running
  logic x_prev_q; // last crystal sample
  logic r_prev_q; // last reference sample
  logic v_samp_q; // gated vco sample
  logic v_prev_q; // previous vco sample
  logic [2:0] pre_cnt_q; // prescaler count
  logic x_rise; // crystal edge
  logic r_rise; // reference edge
  logic v_rise; // vco edge
  logic pre_tick; // prescaler output
  logic ref_pulse; // divided_ref_clock edge
  logic fb_pulse; // vco_feedback_clock edge
  logic det_acq; // detector says tracking
  logic det_lock; // detector says locked
  logic track; // filter mode chosen
  logic lock_flag; // pll_settled_flag as shown
  logic lock_prev_q; // flag one cycle back
  pcg_sel_t sel_st_q; // selector state
  logic sel_src_q; // source now feeding base
  logic [1:0] hold_cnt_q; // source edges held
  logic [5:0] tmo_cnt_q; // cycles held
  logic hold_done; // hold phase over
  logic base_prev_q; // base clock one cycle back
  logic ctrl_wr; // write to control
  logic [DATA_W-1:0] rd_d; // read mux

  // prescaler mask for a power of two
  function automatic logic [2:0] pmask(input logic [1:0] p);
    pmask = 3'((4'h1 << p) - 4'h1);
  endfunction

  // rising edge of the given source
  function automatic logic src_rise(input logic vco, input logic xr, input logic vr);
    src_rise = vco ? vr : xr;
  endfunction

  assign ctrl_wr = reg_wr_in && reg_addr_in == OFS_CTRL;

  // ---- crystal oscillator ----

  // oscillator runs on either enable
  always_ff @(posedge core_clk_in) begin
    if (!nrst_in) begin
      osc_enable_out <= 1'h0;
    end else begin
      osc_enable_out <= sim_osc_enable_in | osc_run_in_stop_in;
    end
  end

  // crystal clock only while the oscillator runs, then buffered
  always_ff @(posedge core_clk_in) begin
    if (!nrst_in) begin
      crystal_clock_out <= 1'h0;
      pll_ref_clock_out <= 1'h0;
      x_prev_q <= 1'h0;
      r_prev_q <= 1'h0;
    end else begin
      crystal_clock_out <= osc_enable_out & xtal_in;
      pll_ref_clock_out <= crystal_clock_out;
      x_prev_q <= crystal_clock_out;
      r_prev_q <= pll_ref_clock_out;
    end
  end

  assign x_rise = crystal_clock_out & ~x_prev_q;
  assign r_rise = pll_ref_clock_out & ~r_prev_q;

  // ---- software registers ----

  // control bits, with the selection interlocks
  always_ff @(posedge core_clk_in) begin
    if (!nrst_in) begin
      ctrl_q <= '0;
    end else begin
      if (ctrl_wr) begin
        ctrl_q.ie <= reg_wdata_in[BIT_IE];
        ctrl_q.auto_bw <= reg_wdata_in[BIT_AUTO];
        // tracking bit is software owned only in manual mode
        if (!reg_wdata_in[BIT_AUTO]) begin
          ctrl_q.acquire_track_select <= reg_wdata_in[BIT_ACQ];
        end
        // power-off refused while the vco is selected as base clock source
        if (reg_wdata_in[BIT_PON] || !ctrl_q.base_source_select) begin
          ctrl_q.pon <= reg_wdata_in[BIT_PON];
        end
        // vco select needs pll already on, unchanged, and L set
        if (!reg_wdata_in[BIT_BCS] || (ctrl_q.pon && reg_wdata_in[BIT_PON] && lin_l_q != '0)) begin
          ctrl_q.base_source_select <= reg_wdata_in[BIT_BCS];
        end
      end
      // zero L forces the crystal back, overriding any write
      if (lin_l_q == '0) begin
        ctrl_q.base_source_select <= 1'h0;
      end
    end
  end

  // divider and range factors
  always_ff @(posedge core_clk_in) begin
    if (!nrst_in) begin
      pre_p_q <= RST_P;
      rng_e_q <= RST_E;
      mod_n_q <= RST_N;
      lin_l_q <= RST_L;
      ref_r_q <= RST_R;
    end else if (reg_wr_in) begin
      unique case (reg_addr_in)
        OFS_PRE: begin
          // E of three is left to software to avoid
          pre_p_q <= reg_wdata_in[PRE_P_LSB +: 2];
          rng_e_q <= reg_wdata_in[PRE_E_LSB +: 2];
        end
        OFS_NLO: begin
          mod_n_q[7:0] <= reg_wdata_in;
        end
        OFS_NHI: begin
          mod_n_q[N_W-1:8] <= reg_wdata_in[N_W-9:0];
        end
        OFS_LRNG: begin
          lin_l_q <= reg_wdata_in;
        end
        OFS_RDIV: begin
          ref_r_q <= reg_wdata_in;
        end
        default: begin
          // control handled above, rest unmapped
        end
      endcase
    end
  end

  // ---- loop ----

  // zero L keeps the loop off whatever the power bit says
  always_ff @(posedge core_clk_in) begin
    if (!nrst_in) begin
      pll_on_q <= 1'h0;
      vco_enable_out <= 1'h0;
      vco_centre_out <= '0;
    end else begin
      pll_on_q <= ctrl_q.pon && lin_l_q != '0;
      vco_enable_out <= ctrl_q.pon && lin_l_q != '0;
      // centre in units of F_NOM_HZ, analog keeps half to twice it
      vco_centre_out <= 11'(lin_l_q) << rng_e_q;
    end
  end

  // vco sampled only while the loop runs
  always_ff @(posedge core_clk_in) begin
    if (!nrst_in) begin
      v_samp_q <= 1'h0;
      v_prev_q <= 1'h0;
    end else begin
      v_samp_q <= vco_clock_in & pll_on_q;
      v_prev_q <= v_samp_q;
    end
  end

  assign v_rise = v_samp_q & ~v_prev_q;

  // power-of-two prescaler on vco edges
  always_ff @(posedge core_clk_in) begin
    if (!nrst_in || !pll_on_q) begin
      pre_cnt_q <= '0;
    end else if (v_rise) begin
      pre_cnt_q <= pre_cnt_q + 3'h1;
    end
  end

  assign pre_tick = v_rise && ((pre_cnt_q & pmask(pre_p_q)) == pmask(pre_p_q));

  // reference divider by R
  pcg_moddiv #(.W(8)) u_ref_div (
    .core_clk_in(core_clk_in),
    .nrst_in(nrst_in),
    .tick_in(r_rise),
    .factor_in(ref_r_q),
    .pulse_out(ref_pulse)
  );

  // feedback divider by N after the prescaler
  pcg_moddiv #(.W(N_W)) u_fb_div (
    .core_clk_in(core_clk_in),
    .nrst_in(nrst_in),
    .tick_in(pre_tick),
    .factor_in(mod_n_q),
    .pulse_out(fb_pulse)
  );

  // phase and frequency comparison
  pcg_detect u_detect (
    .core_clk_in(core_clk_in),
    .nrst_in(nrst_in),
    .run_in(pll_on_q),
    .ref_pulse_in(ref_pulse),
    .fb_pulse_in(fb_pulse),
    .pump_up_out(pump_up_out),
    .pump_dn_out(pump_down_out),
    .acq_out(det_acq),
    .lock_out(det_lock)
  );

  // detector picks the mode in automatic, software in manual
  assign track = ctrl_q.auto_bw ? det_acq : ctrl_q.acquire_track_select;
  // manual mode hides the flag entirely
  assign lock_flag = ctrl_q.auto_bw & det_lock;

  // filter bandwidth, small corrections when tracking
  always_ff @(posedge core_clk_in) begin
    if (!nrst_in) begin
      filter_track_out <= 1'h0;
    end else begin
      filter_track_out <= pll_on_q & track;
    end
  end

  // request on every flag toggle while the interrupt enable is set, never in manual mode
  always_ff @(posedge core_clk_in) begin
    if (!nrst_in) begin
      lock_prev_q <= 1'h0;
      pll_irq_out <= 1'h0;
    end else begin
      lock_prev_q <= lock_flag;
      pll_irq_out <= ctrl_q.auto_bw && ctrl_q.ie && lock_flag != lock_prev_q;
    end
  end

  // ---- base clock selector ----

  // hold counter runs only outside RUN, restarts per phase
  always_ff @(posedge core_clk_in) begin
    if (!nrst_in || sel_st_q == SEL_RUN || hold_done) begin
      hold_cnt_q <= '0;
      tmo_cnt_q <= '0;
    end else begin
      tmo_cnt_q <= tmo_cnt_q + 6'h1;
      if (src_rise(sel_src_q, x_rise, v_rise)) begin
        hold_cnt_q <= hold_cnt_q + 2'h1;
      end
    end
  end

  // a stopped source must not freeze the switch forever
  assign hold_done = hold_cnt_q == HOLD_EDGES || tmo_cnt_q == HOLD_TMO;

  // drain old source, settle new one, then divide by two
  always_ff @(posedge core_clk_in) begin
    if (!nrst_in) begin
      sel_st_q <= SEL_RUN;
      sel_src_q <= 1'h0;
      base_clock_out <= 1'h0;
    end else begin
      unique case (sel_st_q)
        SEL_RUN: begin
          if (ctrl_q.base_source_select != sel_src_q) begin
            sel_st_q <= SEL_DRAIN;
          end else if (src_rise(sel_src_q, x_rise, v_rise)) begin
            base_clock_out <= ~base_clock_out;
          end
        end
        SEL_DRAIN: begin
          // output frozen while the old source runs out
          if (hold_done) begin
            sel_st_q <= SEL_SETTLE;
            sel_src_q <= ctrl_q.base_source_select;
          end
        end
        SEL_SETTLE: begin
          // new source proven before it drives the output
          if (hold_done) begin
            sel_st_q <= SEL_RUN;
          end
        end
        default: begin
          sel_st_q <= SEL_RUN;
        end
      endcase
    end
  end

  // bus clock at half the base clock in user mode
  always_ff @(posedge core_clk_in) begin
    if (!nrst_in) begin
      base_prev_q <= 1'h0;
      bus_clock_out <= 1'h0;
    end else begin
      base_prev_q <= base_clock_out;
      if (user_mode_in && base_clock_out && !base_prev_q) begin
        bus_clock_out <= ~bus_clock_out;
      end
    end
  end

  // ---- register read ----

  // read mux, unmapped offsets read zero
  always_comb begin
    rd_d = '0;
    unique case (reg_addr_in)
      OFS_CTRL: begin
        rd_d[BIT_PON] = ctrl_q.pon;
        rd_d[BIT_BCS] = ctrl_q.base_source_select;
        rd_d[BIT_IE] = ctrl_q.ie;
        rd_d[BIT_AUTO] = ctrl_q.auto_bw;
        rd_d[BIT_ACQ] = track;
        rd_d[BIT_LOCK] = lock_flag;
      end
      OFS_PRE: begin
        rd_d[PRE_P_LSB +: 2] = pre_p_q;
        rd_d[PRE_E_LSB +: 2] = rng_e_q;
      end
      OFS_NLO: begin
        rd_d = mod_n_q[7:0];
      end
      OFS_NHI: begin
        rd_d[N_W-9:0] = mod_n_q[N_W-1:8];
      end
      OFS_LRNG: begin
        rd_d = lin_l_q;
      end
      OFS_RDIV: begin
        rd_d = ref_r_q;
      end
      default: begin
        rd_d = '0;
      end
    endcase
  end

  // read data stand in the cycle after the strobe only
  always_ff @(posedge core_clk_in) begin
    if (!nrst_in || !reg_rd_in) begin
      reg_rdata_out <= '0;
    end else begin
      reg_rdata_out <= rd_d;
    end
  end

  // ---- checks ----

  a_osc_enable_or: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
    ##1 osc_enable_out == $past(sim_osc_enable_in | osc_run_in_stop_in))
    else $error("oscillator enable wrong");

  a_ref_buffered: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
    ##1 pll_ref_clock_out == $past(crystal_clock_out)) else $error("reference not crystal");

  a_vco_sel_legal: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
    ##1 ctrl_q.base_source_select |-> ctrl_q.pon && $past(ctrl_q.pon)) else $error("vco selected with pll off");

  a_pon_off_refused: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
    ctrl_q.base_source_select && ctrl_wr && !reg_wdata_in[BIT_PON] |=> ctrl_q.pon) else $error("pll turned off");

  a_manual_no_irq: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
    !ctrl_q.auto_bw |=> !pll_irq_out) else $error("interrupt in manual mode");

  a_irq_on_toggle: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
    ctrl_q.auto_bw && ctrl_q.ie && $changed(lock_flag) |=> pll_irq_out) else $error("lost lock event");

  a_base_static: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
    sel_st_q != SEL_RUN |=> $stable(base_clock_out)) else $error("base moved in switch");

  a_switch_bounded: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
    sel_st_q == SEL_DRAIN && $past(sel_st_q) == SEL_RUN |-> ##[1:140] sel_st_q == SEL_RUN)
    else $error("source switch hung");

  a_manual_track: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
    !ctrl_q.auto_bw && ctrl_q.acquire_track_select && pll_on_q |=> filter_track_out) else $error("manual track lost");

  a_manual_lock_rd: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
    reg_rd_in && reg_addr_in == OFS_CTRL && !ctrl_q.auto_bw |=> !reg_rdata_out[BIT_LOCK])
    else $error("lock shown in manual mode");
endmodule

// ### rtl/pcg_pkg.sv
// shared constants and types of the pll clock generator
package pcg_pkg;
  // register port geometry and feedback modulo width
  localparam int unsigned ADDR_W = 3;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned N_W = 12;
  // register offsets
  localparam logic [2:0] OFS_CTRL = 3'h0;
  localparam logic [2:0] OFS_PRE = 3'h1;
  localparam logic [2:0] OFS_NLO = 3'h2;
  localparam logic [2:0] OFS_NHI = 3'h3;
  localparam logic [2:0] OFS_LRNG = 3'h4;
  localparam logic [2:0] OFS_RDIV = 3'h5;
  // control register bit positions
  localparam int unsigned BIT_PON = 0;
  localparam int unsigned BIT_BCS = 1;
  localparam int unsigned BIT_IE = 2;
  localparam int unsigned BIT_AUTO = 3;
  localparam int unsigned BIT_ACQ = 4;
  localparam int unsigned BIT_LOCK = 5;
  // prescale register fields
  localparam int unsigned PRE_P_LSB = 0;
  localparam int unsigned PRE_E_LSB = 2;
  // values after reset
  localparam logic [1:0] RST_P = 2'h0;
  localparam logic [1:0] RST_E = 2'h0;
  localparam logic [N_W-1:0] RST_N = 12'h001;
  localparam logic [7:0] RST_L = 8'h00;
  localparam logic [7:0] RST_R = 8'h01;
  // nominal vco step for the centre code, in hertz
  localparam int unsigned F_NOM_HZ = 38400;
  // source edges held on each side of a base clock switch
  localparam logic [1:0] HOLD_EDGES = 2'h3;
  // core cycles before a stalled source is given up on
  localparam logic [5:0] HOLD_TMO = 6'h3F;
  // matching reference periods before tracking and lock
  localparam logic [2:0] ACQ_MATCH = 3'h2;
  localparam logic [2:0] LOCK_MATCH = 3'h4;
  // software control bits
  typedef struct packed {
    logic acquire_track_select;
    logic auto_bw;
    logic ie;
    logic base_source_select;
    logic pon;
  } pcg_ctrl_t;
  // base clock selector states
  typedef enum logic [1:0] {SEL_RUN, SEL_DRAIN, SEL_SETTLE} pcg_sel_t;
endpackage

// ### rtl/pcg_moddiv.sv
// modulo divider: one pulse for every factor ticks
`timescale 1ns/1ns
module pcg_moddiv import pcg_pkg::*; #(
  parameter int unsigned W = 8
) (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic nrst_in,
  // ticks to divide and the factor
  input wire logic tick_in,
  input wire logic [W-1:0] factor_in,
  // divided pulse
  output logic pulse_out
);
  logic [W-1:0] cnt_q; // ticks seen this period
  logic [W-1:0] last; // terminal count

  // zero behaves exactly like one
  assign last = (factor_in == '0) ? '0 : factor_in - 1'h1;

  // count ticks, wrap on the terminal count
  always_ff @(posedge core_clk_in) begin
    if (!nrst_in) begin
      cnt_q <= '0;
      pulse_out <= 1'h0;
    end else begin
      pulse_out <= 1'h0;
      if (tick_in) begin
        // >= so a factor lowered mid-period cannot overrun
        if (cnt_q >= last) begin
          cnt_q <= '0;
          pulse_out <= 1'h1;
        end else begin
          cnt_q <= cnt_q + 1'h1;
        end
      end
    end
  end

  a_zero_factor: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
    tick_in && factor_in == '0 |=> pulse_out) else $error("zero factor did not divide by one");
endmodule

// ### rtl/pcg_detect.sv
// phase detector and frequency lock detector
`timescale 1ns/1ns
module pcg_detect import pcg_pkg::*; (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic nrst_in,
  // loop inputs
  input wire logic run_in,
  input wire logic ref_pulse_in,
  input wire logic fb_pulse_in,
  // correction pulse
  output logic pump_up_out,
  output logic pump_dn_out,
  // frequency state
  output logic acq_out,
  output logic lock_out
);
  logic [1:0] fb_cnt_q; // feedback edges this reference period
  logic [2:0] match_q; // consecutive matching periods
  logic up_d;
  logic dn_d;

  // an edge opens its pump until the other side arrives
  assign up_d = pump_up_out | ref_pulse_in;
  assign dn_d = pump_dn_out | fb_pulse_in;

  // pump width follows the phase gap, direction the leading side
  always_ff @(posedge core_clk_in) begin
    if (!nrst_in || !run_in) begin
      pump_up_out <= 1'h0;
      pump_dn_out <= 1'h0;
    end else if (up_d && dn_d) begin
      pump_up_out <= 1'h0;
      pump_dn_out <= 1'h0;
    end else begin
      pump_up_out <= up_d;
      pump_dn_out <= dn_d;
    end
  end

  // count feedback edges per reference period, at the reference rate
  always_ff @(posedge core_clk_in) begin
    if (!nrst_in || !run_in) begin
      fb_cnt_q <= '0;
      match_q <= '0;
    end else if (ref_pulse_in) begin
      fb_cnt_q <= {1'h0, fb_pulse_in};
      // one feedback edge per period means equal frequency
      if (fb_cnt_q != 2'h1) begin
        match_q <= '0;
      end else if (match_q != LOCK_MATCH) begin
        match_q <= match_q + 3'h1;
      end
    end else if (fb_pulse_in && fb_cnt_q != 2'h3) begin
      fb_cnt_q <= fb_cnt_q + 2'h1;
    end
  end

  // tracking comes before lock, both drop on any miss
  always_ff @(posedge core_clk_in) begin
    if (!nrst_in) begin
      acq_out <= 1'h0;
      lock_out <= 1'h0;
    end else begin
      acq_out <= match_q >= ACQ_MATCH;
      lock_out <= match_q >= LOCK_MATCH;
    end
  end

  a_pump_exclusive: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
    !(pump_up_out && pump_dn_out)) else $error("both pumps on");
endmodule

// ### sim/pcg_clock_gen_tb.sv
// self-checking bench for the pll clock generator
`timescale 1ns/1ns
module pcg_clock_gen_tb import pcg_pkg::*;;
  // design ports
  logic core_clk_in, nrst_in, reg_wr_in, reg_rd_in;
  logic [ADDR_W-1:0] reg_addr_in;
  logic [DATA_W-1:0] reg_wdata_in, reg_rdata_out;
  logic sim_osc_enable_in, osc_run_in_stop_in, xtal_in, vco_clock_in, user_mode_in;
  logic osc_enable_out, crystal_clock_out, pll_ref_clock_out, vco_enable_out;
  logic [10:0] vco_centre_out;
  logic pump_up_out, pump_down_out, filter_track_out, base_clock_out, bus_clock_out, pll_irq_out;
  // bench state
  int error_cnt, checks, cyc, n, tb, tu;
  logic [7:0] v;
  logic x, c, p;
  // values after reset, offsets 6 and 7 unmapped
  logic [7:0] rstv [8] = '{8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00};

  pcg_clock_gen i_dut (.core_clk_in, .nrst_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in,
    .reg_rdata_out, .sim_osc_enable_in, .osc_run_in_stop_in, .xtal_in, .osc_enable_out, .crystal_clock_out,
    .pll_ref_clock_out, .vco_clock_in, .vco_enable_out, .vco_centre_out, .pump_up_out, .pump_down_out,
    .filter_track_out, .user_mode_in, .base_clock_out, .bus_clock_out, .pll_irq_out);

  // 125 MHz core clock
  initial begin
    core_clk_in = 1'b0;
    forever #4 core_clk_in = ~core_clk_in;
  end

  // slow sources: crystal period 16 cycles, vco period 8, so N=2 gives a matched loop
  always @(posedge core_clk_in) begin
    cyc <= cyc + 1;
    xtal_in <= cyc[3];
    vco_clock_in <= cyc[2];
    // hang guard, far beyond the planned run
    if (cyc == 20000) begin
      error_cnt++;
      summarize();
    end
  end

  // compare and count
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // one-cycle write strobe
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge core_clk_in);
    reg_wr_in <= 1'b1;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge core_clk_in);
    reg_wr_in <= 1'b0;
  endtask

  // one-cycle read strobe, data taken in the cycle after it
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge core_clk_in);
    reg_rd_in <= 1'b1;
    reg_addr_in <= a;
    @(posedge core_clk_in);
    reg_rd_in <= 1'b0;
    #1 d = reg_rdata_out;
  endtask

  // toggles of base and bus clocks over len settled cycles
  task automatic cnt(input int len, output int b, output int u);
    logic pb, pu;
    @(posedge core_clk_in);
    #1;
    b = 0;
    u = 0;
    pb = base_clock_out;
    pu = bus_clock_out;
    repeat (len) begin
      @(posedge core_clk_in);
      #1;
      if (base_clock_out !== pb) b++;
      if (bus_clock_out !== pu) u++;
      pb = base_clock_out;
      pu = bus_clock_out;
    end
  endtask

  // verdict and end of run
  task automatic summarize;
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // main sequence
  initial begin
    {nrst_in, reg_wr_in, reg_rd_in, sim_osc_enable_in, osc_run_in_stop_in} = '0;
    {reg_addr_in, reg_wdata_in} = '0;
    user_mode_in = 1'b1;
    {error_cnt, checks} = '0;
    repeat (3) @(posedge core_clk_in);
    nrst_in <= 1'b1;
    // reset values; an unmapped write is dropped
    wr(3'h7, 8'hFF);
    for (int a = 0; a < 8; a++) begin
      rd(a[2:0], v);
      chk("reset value", v, rstv[a]);
    end
    // oscillator enable is an or of both sources
    for (int k = 0; k < 4; k++) begin
      @(posedge core_clk_in);
      sim_osc_enable_in <= k[0];
      osc_run_in_stop_in <= k[1];
      repeat (2) @(posedge core_clk_in);
      #1 chk("osc enable", osc_enable_out, k[0] | k[1]);
    end
    // crystal clock follows the crystal, reference one cycle later
    repeat (40) begin
      x = xtal_in;
      c = crystal_clock_out;
      @(posedge core_clk_in);
      #1 chk("crystal clock", crystal_clock_out, x);
      chk("reference clock", pll_ref_clock_out, c);
    end
    // range, prescale and modulo setup
    wr(OFS_LRNG, 8'h83);
    wr(OFS_PRE, 8'h04);
    wr(OFS_RDIV, 8'h01);
    wr(OFS_NLO, 8'h02);
    // vco select refused while off and together with power on
    wr(OFS_CTRL, 8'h02);
    rd(OFS_CTRL, v);
    chk("select while off", v, 8'h00);
    wr(OFS_CTRL, 8'h03);
    rd(OFS_CTRL, v);
    chk("select with power on", v, 8'h01);
    chk("centre code", vco_centre_out, 11'h106);
    chk("vco enable", vco_enable_out, 1'b1);
    // manual filter mode is software written, after an acquisition wait
    repeat (64) @(posedge core_clk_in);
    wr(OFS_CTRL, 8'h11);
    rd(OFS_CTRL, v);
    chk("manual track", v, 8'h11);
    chk("track out", filter_track_out, 1'b1);
    wr(OFS_CTRL, 8'h01);
    rd(OFS_CTRL, v);
    chk("acquire bit", v, 8'h01);
    chk("acquire out", filter_track_out, 1'b0);
    // automatic mode locks on a matched loop and interrupts
    wr(OFS_CTRL, 8'h0D);
    p = 1'b0;
    for (int i = 0; i < 600 && pll_irq_out !== 1'b1; i++) begin
      @(posedge core_clk_in);
      #1 p = p | pump_up_out | pump_down_out;
    end
    chk("lock irq", pll_irq_out, 1'b1);
    // a pump must open at least once during the lock wait or the 32 cycles after it
    repeat (32) begin
      @(posedge core_clk_in);
      #1 p = p | pump_up_out | pump_down_out;
    end
    chk("pump seen", p, 1'b1);
    rd(OFS_CTRL, v);
    chk("auto locked", v, 8'h3D);
    chk("auto track out", filter_track_out, 1'b1);
    // zero reference factor divides by one, lock must hold
    wr(OFS_RDIV, 8'h00);
    // crystal source: base at source/2, bus at base/2
    cnt(64, tb, tu);
    chk("base on crystal", tb[15:0], 16'h0004);
    chk("bus on crystal", tu[15:0], 16'h0002);
    // switch to vco, base held static meanwhile
    wr(OFS_CTRL, 8'h0F);
    repeat (3) @(posedge core_clk_in);
    #1 x = base_clock_out;
    n = 0;
    while (base_clock_out === x && n < 200) begin
      @(posedge core_clk_in);
      #1 n++;
    end
    chk("switch freeze", n >= 24 && n <= 130, 1'b1);
    rd(OFS_CTRL, v);
    chk("vco selected", v, 8'h3F);
    cnt(64, tb, tu);
    chk("base on vco", tb[15:0], 16'h0008);
    chk("bus on vco", tu[15:0], 16'h0004);
    // bus clock holds outside user mode
    @(posedge core_clk_in);
    user_mode_in <= 1'b0;
    cnt(64, tb, tu);
    chk("bus held", tu[15:0], 16'h0000);
    @(posedge core_clk_in);
    user_mode_in <= 1'b1;
    // power off refused while vco selected
    wr(OFS_CTRL, 8'h0E);
    rd(OFS_CTRL, v);
    chk("power off refused", v, 8'h3F);
    // manual mode hides lock and suppresses interrupts
    wr(OFS_CTRL, 8'h07);
    n = 0;
    repeat (40) begin
      @(posedge core_clk_in);
      #1 if (pll_irq_out === 1'b1) n++;
    end
    chk("manual irq", n[15:0], 16'h0000);
    rd(OFS_CTRL, v);
    chk("manual ctrl", v, 8'h07);
    chk("manual acquire", filter_track_out, 1'b0);
    // zero range factor drops the loop and forces crystal
    wr(OFS_LRNG, 8'h00);
    rd(OFS_CTRL, v);
    chk("zero range", v, 8'h05);
    chk("vco off", vco_enable_out, 1'b0);
    summarize();
  end
endmodule
